//--- rtl/dprcm_cfg.svh
// constants for the dual-port ram with selectable clocking
`ifndef DPRCM_CFG_SVH
`define DPRCM_CFG_SVH

// ****************************************************************
// mode codes, one-hot
// ****************************************************************
`define DPRCM_MODE_INDEP   4'h1
`define DPRCM_MODE_INOUT   4'h2
`define DPRCM_MODE_RDWR    4'h4
`define DPRCM_MODE_SINGLE  4'h8

// ****************************************************************
// clock indices and sizes
// ****************************************************************
`define DPRCM_CLK0         1'h0
`define DPRCM_CLK1         1'h1
`define DPRCM_ADDR_W       8
`define DPRCM_LANES        2
`define DPRCM_LANE_W       8
`define DPRCM_SPLIT_BITS   2048
`define DPRCM_BE_DEFAULT   1'h1

`endif

//--- rtl/dprcm_pkg.sv
// types shared by the dual-port ram files
`include "dprcm_cfg.svh"

package dprcm_pkg;

  typedef enum logic [3:0]
  {
    mode_indep  = `DPRCM_MODE_INDEP,
    mode_inout  = `DPRCM_MODE_INOUT,
    mode_rdwr   = `DPRCM_MODE_RDWR,
    mode_single = `DPRCM_MODE_SINGLE
  } dprcm_mode_t;

endpackage : dprcm_pkg

//--- rtl/dprcm_ram.sv
// two-port storage array with byte lanes and registered read data
`include "dprcm_cfg.svh"

module dprcm_ram #(
  parameter int ADDR_W = `DPRCM_ADDR_W,
  parameter int LANES  = `DPRCM_LANES,
  parameter int LANE_W = `DPRCM_LANE_W
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  input  wire logic                      a_en,
  input  wire logic                      a_we,
  input  wire logic [LANES-1:0]          a_be,
  input  wire logic [ADDR_W-1:0]         a_addr,
  input  wire logic [LANES*LANE_W-1:0]   a_wdata,
  input  wire logic                      a_clr,
  output wire logic [LANES*LANE_W-1:0]   a_q,
  input  wire logic                      b_en,
  input  wire logic                      b_we,
  input  wire logic [LANES-1:0]          b_be,
  input  wire logic [ADDR_W-1:0]         b_addr,
  input  wire logic [LANES*LANE_W-1:0]   b_wdata,
  input  wire logic                      b_clr,
  output wire logic [LANES*LANE_W-1:0]   b_q
);

  import dprcm_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // ****************************************************************
  // one array per byte lane
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_lane
      logic [LANE_W-1:0] mem [0:DEPTH-1];
      logic [LANE_W-1:0] a_q_reg;
      logic [LANE_W-1:0] b_q_reg;

      // a lane is written only with both the select and its enable;
      // on an address collision port b lands last
      always_ff @(posedge ref_clk)
      begin
        if (a_en && a_we && a_be[g])
          mem[a_addr] <= a_wdata[g*LANE_W +: LANE_W];
        if (b_en && b_we && b_be[g])
          mem[b_addr] <= b_wdata[g*LANE_W +: LANE_W];
      end

      // read data hold through a write on the same port
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          a_q_reg <= '0;
        else if (a_clr)
          a_q_reg <= '0;
        else if (a_en && !a_we)
          a_q_reg <= mem[a_addr];
      end

      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          b_q_reg <= '0;
        else if (b_clr)
          b_q_reg <= '0;
        else if (b_en && !b_we)
          b_q_reg <= mem[b_addr];
      end

      assign a_q[g*LANE_W +: LANE_W] = a_q_reg;
      assign b_q[g*LANE_W +: LANE_W] = b_q_reg;
    end
  endgenerate

endmodule : dprcm_ram

//--- rtl/dprcm_top.sv
// dual-port ram with four clocking arrangements over two clock ticks
//
// Summary of operation
// - independent mode: port a runs on clock 0, port b on clock 1
// - independent mode: each port has its own enable and clear
// - in/out mode: clock 0 captures inputs, clock 1 loads outputs
// - in/out mode: input and output groups have separate enables, clears
// - read/write mode: write clock captures write data, address, select
// - read/write mode: read clock drives read address, rden, output
// - read/write mode: one enable per clock, clears per side
// - rden register ignores the clears; every other register obeys them
// - single-port mode: one address on port a, read or write
// - single mode may host two memories of at most 2K bits each
// - one write select per port chooses write or read, except read/write mode: b_we ignored, a_we only gates writes
// - lane written only with select and lane enable; enables tie high
// - output register may be bypassed for one stage less latency
`include "dprcm_cfg.svh"

module dprcm_top #(
  parameter int ADDR_W = `DPRCM_ADDR_W,
  parameter int LANES  = `DPRCM_LANES,
  parameter int LANE_W = `DPRCM_LANE_W
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  input  wire dprcm_pkg::dprcm_mode_t    cfg_mode,
  input  wire logic                      cfg_bypass_a,
  input  wire logic                      cfg_bypass_b,
  input  wire logic                      clk0_tick,
  input  wire logic                      clk0_en,
  input  wire logic                      clk0_clr,
  input  wire logic                      clk1_tick,
  input  wire logic                      clk1_en,
  input  wire logic                      clk1_clr,
  input  wire logic [ADDR_W-1:0]         a_addr,
  input  wire logic [LANES*LANE_W-1:0]   a_wdata,
  input  wire logic                      a_we,
  input  wire logic [LANES-1:0]          a_be,
  output logic      [LANES*LANE_W-1:0]   a_dout,
  output logic                           a_dout_valid,
  input  wire logic [ADDR_W-1:0]         b_addr,
  input  wire logic [LANES*LANE_W-1:0]   b_wdata,
  input  wire logic                      b_we,
  input  wire logic [LANES-1:0]          b_be,
  input  wire logic                      b_rden,
  output logic      [LANES*LANE_W-1:0]   b_dout,
  output logic                           b_dout_valid
);

  import dprcm_pkg::*;

  localparam int DATA_W = LANES * LANE_W;
  localparam int HALF_BITS = ((1 << ADDR_W) * DATA_W) / 2;
  // the array only splits into two single-port memories when small
  localparam bit SPLIT_OK = (HALF_BITS <= `DPRCM_SPLIT_BITS);

  // ****************************************************************
  // clock group selection
  // ****************************************************************
  logic       a_in_sel;
  logic       a_out_sel;
  logic       b_in_sel;
  logic       b_out_sel;
  logic [1:0] tick;
  logic [1:0] ena;
  logic [1:0] clr;

  assign tick = {clk1_tick, clk0_tick};
  assign ena  = {clk1_en, clk0_en};
  assign clr  = {clk1_clr, clk0_clr};

  always_comb
  begin
    a_in_sel  = `DPRCM_CLK0;
    a_out_sel = `DPRCM_CLK0;
    b_in_sel  = `DPRCM_CLK1;
    b_out_sel = `DPRCM_CLK1;
    case (cfg_mode)
      mode_indep:
      begin
        a_in_sel  = `DPRCM_CLK0;
        a_out_sel = `DPRCM_CLK0;
        b_in_sel  = `DPRCM_CLK1;
        b_out_sel = `DPRCM_CLK1;
      end
      mode_inout:
      begin
        a_in_sel  = `DPRCM_CLK0;
        a_out_sel = `DPRCM_CLK1;
        b_in_sel  = `DPRCM_CLK0;
        b_out_sel = `DPRCM_CLK1;
      end
      mode_rdwr:
      begin
        a_in_sel  = `DPRCM_CLK0;
        a_out_sel = `DPRCM_CLK0;
        b_in_sel  = `DPRCM_CLK1;
        b_out_sel = `DPRCM_CLK1;
      end
      mode_single:
      begin
        a_in_sel  = `DPRCM_CLK0;
        a_out_sel = `DPRCM_CLK0;
        b_in_sel  = `DPRCM_CLK1;
        b_out_sel = `DPRCM_CLK1;
      end
      default:
      begin
        a_in_sel  = `DPRCM_CLK0;
        a_out_sel = `DPRCM_CLK0;
        b_in_sel  = `DPRCM_CLK1;
        b_out_sel = `DPRCM_CLK1;
      end
    endcase
  end

  // each group fires on its own clock's tick gated by that clock's
  // enable and is cleared by that clock's clear
  logic a_in_fire;
  logic a_out_fire;
  logic b_in_fire;
  logic b_out_fire;
  logic a_in_clr;
  logic a_out_clr;
  logic b_in_clr;
  logic b_out_clr;

  assign a_in_fire  = tick[a_in_sel] & ena[a_in_sel];
  assign a_out_fire = tick[a_out_sel] & ena[a_out_sel];
  assign b_in_fire  = tick[b_in_sel] & ena[b_in_sel];
  assign b_out_fire = tick[b_out_sel] & ena[b_out_sel];
  assign a_in_clr   = clr[a_in_sel];
  assign a_out_clr  = clr[a_out_sel];
  assign b_in_clr   = clr[b_in_sel];
  assign b_out_clr  = clr[b_out_sel];

  // ****************************************************************
  // port steering per mode
  // ****************************************************************
  logic              mode_rw;
  logic              mode_sp;
  logic              a_en_mem;
  logic              a_we_mem;
  logic [ADDR_W-1:0] a_addr_mem;
  logic              b_en_mem;
  logic              b_we_mem;
  logic [ADDR_W-1:0] b_addr_mem;

  assign mode_rw = (cfg_mode == mode_rdwr);
  assign mode_sp = (cfg_mode == mode_single);

  always_comb
  begin
    a_en_mem   = a_in_fire;
    a_we_mem   = a_we;
    a_addr_mem = a_addr;
    b_en_mem   = b_in_fire;
    b_we_mem   = b_we;
    b_addr_mem = b_addr;
    if (mode_rw)
    begin
      // port a only writes, port b only reads under its rden
      a_en_mem = a_in_fire & a_we;
      b_en_mem = b_in_fire & b_rden;
      b_we_mem = 1'b0;
    end
    else if (mode_sp)
    begin
      if (SPLIT_OK)
      begin
        // lower half for the first memory, upper half for the second
        a_addr_mem = {1'b0, a_addr[ADDR_W-2:0]};
        b_addr_mem = {1'b1, b_addr[ADDR_W-2:0]};
      end
      else
      begin
        b_en_mem = 1'b0;
      end
    end
  end

  // ****************************************************************
  // storage array
  // ****************************************************************
  logic [DATA_W-1:0] a_q;
  logic [DATA_W-1:0] b_q;

  dprcm_ram #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_ram (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .a_en    (a_en_mem),
    .a_we    (a_we_mem),
    .a_be    (a_be),
    .a_addr  (a_addr_mem),
    .a_wdata (a_wdata),
    .a_clr   (a_in_clr),
    .a_q     (a_q),
    .b_en    (b_en_mem),
    .b_we    (b_we_mem),
    .b_be    (b_be),
    .b_addr  (b_addr_mem),
    .b_wdata (b_wdata),
    .b_clr   (b_in_clr),
    .b_q     (b_q)
  );

  // ****************************************************************
  // read tracking and rden register
  // ****************************************************************
  logic a_rd_reg;
  logic b_rd_reg;
  logic rden_reg;

  // marks that the read register took fresh data on the last cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      a_rd_reg <= 1'b0;
    else if (a_in_clr)
      a_rd_reg <= 1'b0;
    else
      a_rd_reg <= a_en_mem & ~a_we_mem;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      b_rd_reg <= 1'b0;
    else if (b_in_clr)
      b_rd_reg <= 1'b0;
    else
      b_rd_reg <= b_en_mem & ~b_we_mem;
  end

  // deliberately immune to the group clears; reset clears it, b_in_fire loads b_rden
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rden_reg <= 1'b0;
    else if (b_in_fire)
      rden_reg <= b_rden;
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  logic a_load;
  logic b_load;

  // bypass loads straight after the read instead of on the output tick
  assign a_load = cfg_bypass_a ? a_rd_reg : a_out_fire;
  assign b_load = cfg_bypass_b ? b_rd_reg
                : (b_out_fire & (~mode_rw | rden_reg));

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      a_dout       <= '0;
      a_dout_valid <= 1'b0;
    end
    else if (a_out_clr)
    begin
      a_dout       <= '0;
      a_dout_valid <= 1'b0;
    end
    else
    begin
      a_dout_valid <= a_load & ~mode_rw;
      if (a_load && !mode_rw)
        a_dout <= a_q;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      b_dout       <= '0;
      b_dout_valid <= 1'b0;
    end
    else if (b_out_clr)
    begin
      b_dout       <= '0;
      b_dout_valid <= 1'b0;
    end
    else
    begin
      b_dout_valid <= b_load;
      if (b_load)
        b_dout <= b_q;
    end
  end

endmodule : dprcm_top

//--- verification/dprcm_ticker.sv
// far-side model: two free-running user clock ticks from the fabric
module dprcm_ticker #(
  parameter int GAP0 = 2,
  parameter int GAP1 = 4
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  output logic      clk0_tick,
  output logic      clk1_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  int c0;
  int c1;
  // unequal periods keep the two user clocks out of step
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      c0 <= 0;
    else
      c0 <= (c0 == GAP0) ? 0 : c0 + 1;
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      c1 <= 0;
    else
      c1 <= (c1 == GAP1) ? 0 : c1 + 1;
  end
  assign clk0_tick = reset_n && (c0 == GAP0);
  assign clk1_tick = reset_n && (c1 == GAP1);
endmodule : dprcm_ticker

//--- verification/dprcm_top_asserts.sv
// port-level checker for the dual-port ram clocking modes
`include "dprcm_cfg.svh"

module dprcm_top_asserts #(
  parameter int ADDR_W = `DPRCM_ADDR_W,
  parameter int LANES  = `DPRCM_LANES,
  parameter int LANE_W = `DPRCM_LANE_W
) (
  input wire logic                    ref_clk,
  input wire logic                    reset_n,
  input wire dprcm_pkg::dprcm_mode_t  cfg_mode,
  input wire logic                    cfg_bypass_a,
  input wire logic                    cfg_bypass_b,
  input wire logic                    clk0_tick,
  input wire logic                    clk0_en,
  input wire logic                    clk0_clr,
  input wire logic                    clk1_tick,
  input wire logic                    clk1_en,
  input wire logic                    clk1_clr,
  input wire logic                    a_we,
  input wire logic [LANES*LANE_W-1:0] a_dout,
  input wire logic                    a_dout_valid,
  input wire logic                    b_rden,
  input wire logic [LANES*LANE_W-1:0] b_dout,
  input wire logic                    b_dout_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  import dprcm_pkg::*;
  // ************************************************
  // properties
  // ************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_a_byp;
    cfg_mode == mode_indep && cfg_bypass_a && clk0_tick && clk0_en && !a_we
      && !clk0_clr ##1 !clk0_clr |-> ##1 a_dout_valid;
  endproperty
  a_a_byp: assert property (p_a_byp)
    else $error("bypassed read gave no data");
  property p_a_cause;
    cfg_mode == mode_indep && cfg_bypass_a && a_dout_valid
      |-> $past(clk0_tick && clk0_en && !a_we, 2);
  endproperty
  a_a_cause: assert property (p_a_cause)
    else $error("port a data without enabled read");
  property p_indep_reg;
    cfg_mode == mode_indep && !cfg_bypass_a && a_dout_valid
      |-> $past(clk0_tick && clk0_en);
  endproperty
  a_indep_reg: assert property (p_indep_reg)
    else $error("port a output not on its own clock");
  property p_inout_out;
    cfg_mode == mode_inout && !cfg_bypass_b && b_dout_valid
      |-> $past(clk1_tick && clk1_en);
  endproperty
  a_inout_out: assert property (p_inout_out)
    else $error("port b output not on output clock");
  property p_rdwr_a;
    (cfg_mode == mode_rdwr) [*3] |-> !a_dout_valid;
  endproperty
  a_rdwr_a: assert property (p_rdwr_a)
    else $error("write port produced read data");
  property p_rden;
    cfg_mode == mode_rdwr && cfg_bypass_b && b_dout_valid
      |-> $past(clk1_tick && clk1_en && b_rden, 2);
  endproperty
  a_rden: assert property (p_rden)
    else $error("read without read enable");
  property p_clr_a;
    cfg_mode == mode_indep && clk0_clr |=> a_dout == '0;
  endproperty
  a_clr_a: assert property (p_clr_a)
    else $error("port a clear ignored");
  property p_clr_out;
    cfg_mode == mode_inout && clk1_clr |=> a_dout == '0 && b_dout == '0;
  endproperty
  a_clr_out: assert property (p_clr_out)
    else $error("output group clear ignored");
  property p_hold;
    !a_dout_valid && !$past(clk0_clr) && !$past(clk1_clr) |-> $stable(a_dout);
  endproperty
  a_hold: assert property (p_hold)
    else $error("port a output moved without load");
  c_byp: cover property (a_dout_valid && cfg_bypass_a);
  c_rden: cover property (cfg_mode == mode_rdwr && b_dout_valid);
  c_single: cover property (cfg_mode == mode_single && b_dout_valid);
endmodule : dprcm_top_asserts

bind dprcm_top dprcm_top_asserts #(.ADDR_W(ADDR_W), .LANES(LANES),
  .LANE_W(LANE_W)) dprcm_top_asserts_i (.*);

//--- verification/dprcm_top_tb.sv
// self-checking bench for the dual-port ram clocking modes
module dprcm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dprcm_pkg::*;
  logic        ref_clk = 1'h0, reset_n = 1'h0;
  dprcm_mode_t cfg_mode = mode_indep;
  logic        cfg_bypass_a = 1'h1, cfg_bypass_b = 1'h1;
  logic        clk0_tick, clk0_en = 1'h0, clk0_clr = 1'h0;
  logic        clk1_tick, clk1_en = 1'h0, clk1_clr = 1'h0;
  logic [7:0]  a_addr = 8'h00, b_addr = 8'h00;
  logic [15:0] a_wdata = 16'h0000, b_wdata = 16'h0000, a_dout, b_dout;
  logic        a_we = 1'h0, b_we = 1'h0, b_rden = 1'h0;
  logic        a_dout_valid, b_dout_valid;
  logic [1:0]  a_be = 2'h3, b_be = 2'h3;
  int          err_count = 0, cmp_count = 0;

  dprcm_top dprcm_top_i (.*);
  dprcm_ticker dprcm_ticker_i (.*);
  always #50 ref_clk = ~ref_clk;

  // ************************************************
  // tasks
  // ************************************************
  task automatic conclude();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic fail(input string m);
    $display("[ERR] %0t %s", $time, m);
    err_count++;
  endtask : fail
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
      fail($sformatf("dout %h expected %h", got, exp));
  endtask : chk
  // hold the enable until a tick of group g is taken
  task automatic fire(input logic g);
    int n;
    clk0_en <= !g;
    clk1_en <= g;
    for (n = 0; n < 40; n++)
    begin
      @(posedge ref_clk);
      if (g ? clk1_tick && clk1_en : clk0_tick && clk0_en)
        break;
    end
    if (n == 40)
    begin
      fail("no tick taken");
      conclude();
    end
    clk0_en <= 1'h0;
    clk1_en <= 1'h0;
  endtask : fire
  task automatic acc(input logic p, input logic we, input logic [1:0] be,
                     input logic rd, input logic [7:0] ad,
                     input logic [15:0] d);
    @(posedge ref_clk);
    if (p)
    begin
      b_we <= we;
      b_be <= be;
      b_rden <= rd;
      b_addr <= ad;
      b_wdata <= d;
    end
    else
    begin
      a_we <= we;
      a_be <= be;
      a_addr <= ad;
      a_wdata <= d;
    end
    fire(p && cfg_mode != mode_inout);
    a_we <= 1'h0;
    b_we <= 1'h0;
  endtask : acc
  task automatic rd_chk(input logic p, input logic [15:0] exp);
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(negedge ref_clk);
      if ((p ? b_dout_valid : a_dout_valid) === 1'h1)
        break;
    end
    if (n == 40)
    begin
      fail("no read data");
      conclude();
    end
    chk(p ? b_dout : a_dout, exp);
  endtask : rd_chk
  task automatic clr(input logic g);
    @(posedge ref_clk);
    clk0_clr <= !g;
    clk1_clr <= g;
    @(posedge ref_clk);
    clk0_clr <= 1'h0;
    clk1_clr <= 1'h0;
    @(negedge ref_clk);
  endtask : clr

  // ************************************************
  // sequence
  // ************************************************
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'h1;
    acc(0, 1, 2'h3, 0, 8'h10, 16'h1234);
    acc(1, 1, 2'h2, 0, 8'h10, 16'hABCD);
    acc(0, 1, 2'h0, 0, 8'h10, 16'h0000);
    @(posedge ref_clk);
    // write select with the enable low must leave the array alone
    a_we <= 1'h1;
    a_be <= 2'h3;
    a_wdata <= 16'hFFFF;
    repeat (8) @(posedge ref_clk);
    a_we <= 1'h0;
    repeat (2)
    begin
      acc(0, 0, 2'h3, 0, 8'h10, 16'hFFFF);
      rd_chk(0, 16'hAB34);
    end
    acc(1, 0, 2'h3, 0, 8'h10, 16'h0000);
    rd_chk(1, 16'hAB34);
    @(posedge ref_clk);
    cfg_bypass_a <= 1'h0;
    acc(0, 0, 2'h3, 0, 8'h10, 16'h0000);
    acc(0, 0, 2'h3, 0, 8'h20, 16'h0000);
    rd_chk(0, 16'hAB34);
    clr(1);
    chk(a_dout, 16'hAB34);
    clr(0);
    chk(a_dout, 16'h0000);
    @(posedge ref_clk);
    cfg_mode <= mode_inout;
    cfg_bypass_b <= 1'h0;
    acc(1, 1, 2'h3, 0, 8'h30, 16'h5A5A);
    acc(1, 0, 2'h3, 0, 8'h30, 16'h0000);
    @(posedge ref_clk);
    fire(1);
    rd_chk(1, 16'h5A5A);
    clr(0);
    chk(b_dout, 16'h5A5A);
    clr(1);
    chk(b_dout, 16'h0000);
    @(posedge ref_clk);
    cfg_mode <= mode_rdwr;
    cfg_bypass_b <= 1'h1;
    acc(0, 1, 2'h3, 0, 8'h40, 16'h0F0F);
    acc(1, 1, 2'h3, 0, 8'h40, 16'h1111);
    acc(1, 0, 2'h3, 0, 8'h40, 16'h0000);
    acc(0, 0, 2'h3, 0, 8'h40, 16'h0000);
    acc(1, 0, 2'h3, 1, 8'h40, 16'h0000);
    rd_chk(1, 16'h0F0F);
    clr(1);
    chk(b_dout, 16'h0000);
    @(posedge ref_clk);
    // registered read side: the rden register survives the clear
    cfg_bypass_b <= 1'h0;
    acc(1, 0, 2'h3, 0, 8'h40, 16'h0000);
    rd_chk(1, 16'h0000);
    acc(1, 0, 2'h3, 1, 8'h40, 16'h0000);
    acc(1, 0, 2'h3, 0, 8'h40, 16'h0000);
    rd_chk(1, 16'h0F0F);
    @(posedge ref_clk);
    cfg_mode <= mode_single;
    cfg_bypass_a <= 1'h1;
    cfg_bypass_b <= 1'h1;
    acc(0, 1, 2'h3, 0, 8'h05, 16'h1357);
    acc(1, 1, 2'h3, 0, 8'h05, 16'h2468);
    acc(0, 0, 2'h3, 0, 8'h05, 16'h0000);
    rd_chk(0, 16'h1357);
    acc(1, 0, 2'h3, 0, 8'h05, 16'h0000);
    rd_chk(1, 16'h2468);
    conclude();
  end
endmodule : dprcm_top_tb
